// ### hdl/rail_phase_config.sv
// rail phase configuration register and phase offset computation
`timescale 1ns/10ps
`include "rail_phase_cfg.svh"
module rail_phase_config #(
   parameter int PERIOD_W = 16
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [6:0] strap_addr,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic [PERIOD_W-1:0] period_ticks,
   output logic [15:0] cmd_rdata,
   output logic cmd_ack,
   output logic [2:0] phase_position,
   output logic [4:0] rail_identifier,
   output logic [3:0] phases_in_rail,
   output logic [PERIOD_W-1:0] phase_offset,
   output logic offset_valid
);
   ////////////////////////////////////////////////////////////////////////////
   // reset enters asynchronously but leaves on the clock, so no flop sees a late edge
   logic rst_s1_q, rst_q;
   logic rst_s1_d, rst_d;
   always_comb begin
      rst_s1_d = 1'b1;
      rst_d = rst_s1_q;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_s1_q <= rst_s1_d;
         rst_q <= rst_d;
      end
   end
   // strap pins are async: two stages before use
   logic [6:0] strap_s1_q, strap_q;
   logic [6:0] strap_s1_d, strap_d;
   always_comb begin
      strap_s1_d = strap_addr;
      strap_d = strap_s1_q;
   end
   always_ff @(posedge ref_clk) begin
      strap_s1_q <= strap_s1_d;
      strap_q <= strap_d;
   end
   ////////////////////////////////////////////////////////////////////////////
   rail_phase_pkg::rail_cfg_s cfg_q, cfg_d;
   rail_phase_pkg::cmd_req_s req;
   logic loaded_q, loaded_d;
   logic load_wait_q, load_wait_d;
   logic [15:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic hit;
   logic wr_hit;
   logic rd_any;
   assign req = '{wr: cmd_wr, rd: cmd_rd, cmd: cmd_code, wdata: cmd_wdata};
   assign hit = (req.cmd == `RPC_CMD_CODE);
   assign wr_hit = req.wr && hit;
   assign rd_any = req.rd;
   always_comb begin
      cfg_d = cfg_q;
      load_wait_d = 1'b1;
      loaded_d = load_wait_q;
      rdata_d = rdata_q;
      ack_d = 1'b0;
      // strap copy taken once the synchroniser has settled after release;
      // commands in these first cycles are dropped rather than racing the strap
      if (!loaded_q) begin
         cfg_d.rail_identifier = strap_q[4:0]; // R8
      end else if (wr_hit) begin
         cfg_d.phase_position = req.wdata[`RPC_POS_MSB:`RPC_POS_LSB]; // R1
         cfg_d.rail_identifier = req.wdata[`RPC_RAIL_MSB:`RPC_RAIL_LSB]; // R2
         cfg_d.phase_count = req.wdata[`RPC_CNT_MSB:`RPC_CNT_LSB]; // R3
         cfg_d.unused = 5'h00; // R9
         ack_d = 1'b1;
      end else if (rd_any) begin
         // other codes belong to other registers: answer zero and stay silent
         rdata_d = hit ? (cfg_q & `RPC_UNUSED_MASK) : 16'h0000; // R9
         ack_d = hit;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         // rail field is filled from the strap a few cycles after release
         cfg_q.phase_position <= `RPC_POS_RESET;
         cfg_q.rail_identifier <= 5'h00;
         cfg_q.unused <= 5'h00;
         cfg_q.phase_count <= `RPC_CNT_RESET; // R8
         loaded_q <= 1'b0;
         load_wait_q <= 1'b0;
         rdata_q <= 16'h0000;
         ack_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         loaded_q <= loaded_d;
         load_wait_q <= load_wait_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // offset = position * period / (count+1) by restoring division; sequential
   // to avoid a wide combinational divider, result lags a config change
   localparam int PW = PERIOD_W + 3;
   rail_phase_pkg::off_state_e st_q, st_d;
   logic [PW-1:0] num_q, num_d;
   logic [PW-1:0] quo_q, quo_d;
   logic [PW:0] rem_q, rem_d;
   logic [5:0] bit_q, bit_d;
   logic [PERIOD_W-1:0] off_q, off_d;
   logic val_q, val_d;
   logic [7:0] snap_q, snap_d;
   logic [7:0] snap_now;
   logic restart;
   logic [3:0] divisor;
   logic [PW:0] div_ext;
   logic [PW:0] trial;
   logic [PW-1:0] num_start;
   logic last_bit;
   assign divisor = {1'b0, cfg_q.phase_count} + 4'h1; // R3 R5
   assign div_ext = {{(PW-3){1'b0}}, divisor};
   assign trial = {rem_q[PW-1:0], num_q[PW-1]};
   assign snap_now = {cfg_q.phase_position, cfg_q.phase_count, 2'b00};
   assign restart = (snap_q != snap_now);
   assign num_start = PW'(cfg_q.phase_position) * PW'(period_ticks); // R9 R4
   assign last_bit = (bit_q == 6'h01);
   always_comb begin
      st_d = st_q;
      num_d = num_q;
      quo_d = quo_q;
      rem_d = rem_q;
      bit_d = bit_q;
      off_d = off_q;
      val_d = val_q;
      snap_d = snap_q;
      case (st_q)
         rail_phase_pkg::off_idle: begin
            // valid clears at reset, so a divide also starts right after release
            if (restart || !val_q) begin
               num_d = num_start;
               quo_d = '0;
               rem_d = '0;
               bit_d = 6'(PW);
               snap_d = snap_now;
               val_d = 1'b0;
               st_d = rail_phase_pkg::off_div;
            end
         end
         rail_phase_pkg::off_div: begin
            // a write that changes position or count during the divide restarts it, but a stale quotient still shows valid for one cycle after a write lands in idle
            if (restart) begin
               st_d = rail_phase_pkg::off_idle;
            end else begin
               num_d = {num_q[PW-2:0], 1'b0};
               if (trial >= div_ext) begin
                  rem_d = trial - div_ext;
                  quo_d = {quo_q[PW-2:0], 1'b1};
               end else begin
                  rem_d = trial;
                  quo_d = {quo_q[PW-2:0], 1'b0};
               end
               bit_d = bit_q - 6'h01;
               if (last_bit) begin
                  off_d = quo_d[PERIOD_W-1:0]; // R4
                  val_d = 1'b1;
                  st_d = rail_phase_pkg::off_idle;
               end
            end
         end
         default: st_d = rail_phase_pkg::off_idle;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         st_q <= rail_phase_pkg::off_idle;
         num_q <= '0;
         quo_q <= '0;
         rem_q <= '0;
         bit_q <= 6'h00;
         off_q <= '0;
         val_q <= 1'b0;
         snap_q <= 8'h00;
      end else begin
         st_q <= st_d;
         num_q <= num_d;
         quo_q <= quo_d;
         rem_q <= rem_d;
         bit_q <= bit_d;
         off_q <= off_d;
         val_q <= val_d;
         snap_q <= snap_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // registered so every output comes straight from a flop
   logic [3:0] pir_q, pir_d;
   always_comb begin
      pir_d = divisor; // R5
   end
   always_ff @(posedge ref_clk or negedge rst_q) begin
      if (!rst_q) begin
         pir_q <= 4'h1;
      end else begin
         pir_q <= pir_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // phase_offset keeps only the low PERIOD_W bits, so a position above the
   // phase count with a very long period wraps
   assign cmd_rdata = rdata_q;
   assign cmd_ack = ack_q;
   assign phase_position = cfg_q.phase_position;
   assign rail_identifier = cfg_q.rail_identifier;
   assign phases_in_rail = pir_q;
   assign phase_offset = off_q;
   assign offset_valid = val_q;
endmodule : rail_phase_config

// ### hdl/rail_phase_cfg.svh
// constants for the rail phase configuration register
// Operation
// [R1] phase position field in bits 15:13
// [R2] rail identifier field in bits 12:8
// [R3] phase count field, value plus one
// [R4] members spread phase offsets evenly around period
// [R5] rails hold up to eight devices
// [R6] host sets same rail, count, positions sequentially
// [R7] host sets same group, group message response
// [R8] reset loads rail from strapped address low bits
// [R9] offset is position times period over count
`ifndef RAIL_PHASE_CFG_SVH
`define RAIL_PHASE_CFG_SVH
`define RPC_CMD_CODE 8'hD3
`define RPC_POS_MSB 15
`define RPC_POS_LSB 13
`define RPC_RAIL_MSB 12
`define RPC_RAIL_LSB 8
`define RPC_CNT_MSB 2
`define RPC_CNT_LSB 0
`define RPC_POS_RESET 3'h0
`define RPC_CNT_RESET 3'h0
`define RPC_UNUSED_MASK 16'hFF07
`define RPC_PERIOD_RESET 16'h0064
`endif

// ### hdl/rail_phase_pkg.sv
// types for the rail phase configuration register
package rail_phase_pkg;
   typedef struct packed {
      logic [2:0] phase_position;
      logic [4:0] rail_identifier;
      logic [4:0] unused;
      logic [2:0] phase_count;
   } rail_cfg_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] cmd;
      logic [15:0] wdata;
   } cmd_req_s;
   typedef enum logic [1:0] {off_idle, off_div} off_state_e;
endpackage : rail_phase_pkg

// ### sim/rail_phase_checker.sv
// assertions on the rail phase configuration ports
`timescale 1ns/10ps
`include "rail_phase_cfg.svh"
module rail_phase_checker #(parameter int PERIOD_W = 16) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic cmd_ack,
   input wire logic offset_valid,
   input wire logic [6:0] strap_addr,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic [15:0] cmd_rdata,
   input wire logic [2:0] phase_position,
   input wire logic [4:0] rail_identifier,
   input wire logic [3:0] phases_in_rail,
   input wire logic [PERIOD_W-1:0] period_ticks,
   input wire logic [PERIOD_W-1:0] phase_offset
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_hit; (cmd_wr || cmd_rd) && cmd_code == `RPC_CMD_CODE; endsequence
   sequence s_wr; cmd_wr && cmd_code == `RPC_CMD_CODE; endsequence
   a_pos_write: assert property (s_wr |=> phase_position == $past(cmd_wdata[15:13]))
      else $error("position not taken");
   a_rail_write: assert property (s_wr |=> rail_identifier == $past(cmd_wdata[12:8]))
      else $error("rail not taken");
   a_count_plus_one: assert property (s_wr |=> ##1 phases_in_rail == {1'b0, $past(cmd_wdata[2:0], 2)} + 4'h1)
      else $error("count wrong");
   a_count_range: assert property (phases_in_rail inside {[4'h1:4'h8]})
      else $error("count out of range");
   a_unused_zero: assert property (cmd_ack |-> cmd_rdata[7:3] == 5'h00)
      else $error("unused bits set");
   a_ack_hit: assert property (s_hit |=> cmd_ack)
      else $error("no ack");
   a_offset_even: assert property ($rose(offset_valid) |->
      32'(phase_offset) == 32'(phase_position) * 32'(period_ticks) / 32'(phases_in_rail))
      else $error("offset wrong");
   a_strap_load: assert property ($rose(rstn) |-> ##[1:8] rail_identifier == strap_addr[4:0])
      else $error("strap not loaded");
endmodule : rail_phase_checker
bind rail_phase_config rail_phase_checker #(.PERIOD_W(PERIOD_W)) rail_phase_checker_inst (.*);

// ### sim/rail_host.sv
// management bus host model issuing register commands
`timescale 1ns/10ps
module rail_host (
   input wire logic ref_clk,
   input wire logic cmd_ack,
   input wire logic [15:0] cmd_rdata,
   output rail_phase_pkg::cmd_req_s req
);
   initial req = '0;
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
      output logic [15:0] q, output logic ok);
      ok = 0;
      q = 16'h0000;
      @(negedge ref_clk);
      req = '{w, !w, c, d};
      @(negedge ref_clk);
      // released data flips so a stale value never looks valid
      req = '{1'b0, 1'b0, c, ~d};
      for (int i = 0; i < 3 && !ok; i++) begin
         if (cmd_ack === 1'b1) begin
            ok = 1;
            q = cmd_rdata;
         end
         else @(negedge ref_clk);
      end
   endtask : xfer
endmodule : rail_host

// ### sim/test_rail_phase_config.sv
// self-checking bench for the rail phase configuration register
`timescale 1ns/10ps
module test_rail_phase_config;
   logic ref_clk = 0, rstn = 0, cmd_ack, offset_valid, ok;
   logic [15:0] cmd_rdata, q, phase_offset;
   logic [2:0] phase_position;
   logic [4:0] rail_identifier;
   logic [6:0] strap = 7'h5A;
   logic [15:0] period = 16'h0064;
   logic [3:0] phases_in_rail;
   rail_phase_pkg::cmd_req_s req;
   int failures = 0, checked = 0;
   always #20 ref_clk = ~ref_clk;
   rail_phase_config rail_phase_config_inst (.ref_clk, .rstn, .strap_addr(strap), .cmd_wr(req.wr),
      .cmd_rd(req.rd), .cmd_code(req.cmd), .cmd_wdata(req.wdata), .period_ticks(period), .cmd_rdata,
      .cmd_ack, .phase_position, .rail_identifier, .phases_in_rail, .phase_offset, .offset_valid);
   rail_host rail_host_inst (.ref_clk, .cmd_ack, .cmd_rdata, .req);
   task results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   task check(input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch %0t seen %h want %h", $time, s, e);
      end
   endtask : check
   task acc(input logic w, input logic [7:0] c, input logic [15:0] d, input logic k);
      rail_host_inst.xfer(w, c, d, q, ok);
      check(ok, k);
      if (ok !== k) results;
   endtask : acc
   task settle(input logic [15:0] e);
      // one edge first, so a just-written config has dropped valid
      @(negedge ref_clk);
      for (int i = 0; i < 60 && offset_valid !== 1'b1; i++) @(negedge ref_clk);
      if (offset_valid !== 1'b1) begin
         failures++;
         results;
      end else begin
         check(phase_offset, e);
      end
   endtask : settle
   task t_reset;
      acc(0, 8'hD3, 0, 1);
      check(q, 16'h1A00);
      check(phases_in_rail, 1);
      $display("reset test done");
   endtask : t_reset
   task t_fields;
      for (int c = 0; c < 8; c++) begin
         acc(1, 8'hD3, {3'(7 - c), 5'(c * 3), 5'h1F, 3'(c)}, 1);
         acc(0, 8'hD3, 0, 1);
         check(q, {3'(7 - c), 5'(c * 3), 5'h00, 3'(c)});
         check(phases_in_rail, 16'(c + 1));
         settle(16'((7 - c) * 100 / (c + 1)));
      end
      $display("field test done");
   endtask : t_fields
   task t_two_phase;
      acc(1, 8'hD3, 16'h0701, 1);
      acc(1, 8'hD3, 16'h2701, 1);
      acc(0, 8'hD3, 0, 1);
      check(phase_position, 1);
      check(rail_identifier, 7);
      settle(16'h0032);
      $display("two phase test done");
   endtask : t_two_phase
   task t_refused;
      acc(1, 8'hD4, 16'hFFFF, 0);
      acc(0, 8'hD4, 0, 0);
      acc(0, 8'hD3, 0, 1);
      check(q, 16'h2701);
      $display("refused test done");
   endtask : t_refused
   task t_restrap;
      strap = 7'h25;
      period = 16'h00C8;
      rstn = 0;
      repeat (2) @(negedge ref_clk);
      rstn = 1;
      repeat (8) @(negedge ref_clk);
      acc(0, 8'hD3, 0, 1);
      check(q, 16'h0500);
      acc(1, 8'hD3, 16'h4003, 1);
      acc(0, 8'hD3, 0, 1);
      check(q, 16'h4003);
      settle(16'h0064);
      $display("restrap test done");
   endtask : t_restrap
   initial begin
      repeat (2) @(negedge ref_clk);
      rstn = 1;
      repeat (8) @(negedge ref_clk);
      t_reset;
      t_fields;
      t_two_phase;
      t_refused;
      t_restrap;
      results;
   end
endmodule : test_rail_phase_config
